// file: src/awm_defs.svh
`ifndef AWM_DEFS_SVH
`define AWM_DEFS_SVH

// =====================================================================
// register offsets
`define AWM_PA_GOAL_HIGH     8'h16
`define AWM_PA_GOAL_LOW      8'h17
`define AWM_TEMP_GOAL        8'h18
`define AWM_PA_BAND_HIGH     8'h19
`define AWM_PA_BAND_LOW      8'h1A
`define AWM_TEMP_BAND        8'h1B
`define AWM_LOW_PA_HIGH      8'h1C
`define AWM_LOW_PA_MID       8'h1D
`define AWM_LOW_PA_LOW       8'h1E
`define AWM_LOW_TEMP_HIGH    8'h1F
`define AWM_LOW_TEMP_LOW     8'h20
`define AWM_HIGH_PA_HIGH     8'h21
`define AWM_HIGH_PA_MID      8'h22
`define AWM_HIGH_PA_LOW      8'h23

// =====================================================================
// reset values and field layout
`define AWM_RESET_BYTE       8'h00
`define AWM_UNMAPPED_READ    8'h00
`define AWM_LOW_NIBBLE_ZERO  4'h0
`define AWM_ALT_FRAC_BITS    4
`define AWM_PRESS_UNIT_SHIFT 3
`define AWM_LEVEL_LOWER      0
`define AWM_LEVEL_CENTRE     1
`define AWM_LEVEL_UPPER      2
`define AWM_ALL_LEVELS       3'h7
`define AWM_CENTRE_ONLY      3'h2

`endif

// file: src/awm_pkg.sv
// =====================================================================
// shared types of the alarm window and min/max capture block
package awm_pkg;

    typedef enum logic {
        AWM_BAROMETER = 1'b0,
        AWM_ALTIMETER = 1'b1
    } awm_mode_t;

    // one register access from the host serial port
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } awm_reg_req_t;

    // one completed conversion
    typedef struct packed {
        logic [19:0] press;
        logic [11:0] temp;
    } awm_sample_t;

endpackage

// file: src/awm_alarm_capture.sv
`timescale 1ns/100ps
`include "awm_defs.svh"
// Function
// - altitude mode: pressure/altitude goal is signed 16-bit whole meters
// - pressure mode: the same goal is unsigned 16-bit in 2 Pa steps
// - band alert flag set when reading lies within goal plus/minus band
// - no pressure/altitude band alert while the band pair is zero
// - temperature goal is signed degrees; flag readings within goal +/- band
// - no temperature band alert while the temperature band is zero
// - pressure/altitude band is unsigned 16-bit, meters or 2 Pa steps
// - flag any pressure/altitude crossing of lower, centre or upper level
// - temperature band unsigned 8-bit; flag any crossing of its three levels
// - hold the lowest pressure/altitude reading in three bytes
// - hold the highest pressure/altitude reading in three bytes
// - altitude extremes: signed 20-bit, 16 integer bits, 4-bit fraction
// - pressure extremes: 18 integer bits and 2-bit fraction, in Pascals
// - hold the lowest temperature reading in two bytes
// - temperature extremes: signed 12-bit, 8 integer, 4-bit fraction
// - extremes zero after reset; host clears them by writing zero
// - mode bit one selects altitude, zero selects pressure
// - zero band: centre crossing only; otherwise any of three levels
// - band alert status needs a non-zero band to trigger
module awm_alarm_capture
    import awm_pkg::*;
(
    input  wire logic         core_clk,
    input  wire logic         reset_n,
    input  wire awm_reg_req_t reg_req,
    input  wire logic         altimeter_select,
    input  wire logic         sample_valid,
    input  wire awm_sample_t  sample,
    output logic [7:0]        reg_rdata,
    output logic              press_band_alert_status,
    output logic              press_threshold_cross_status,
    output logic              temp_band_alert_status,
    output logic              temp_threshold_cross_status
);

    // =================================================================
    // register storage
    logic [15:0]        press_alt_goal;
    logic [15:0]        press_alt_band;
    logic [7:0]         temp_goal;
    logic [7:0]         temp_band;
    logic [19:0]        lowest_press_alt;
    logic [19:0]        highest_press_alt;
    logic [11:0]        lowest_temp;
    logic               lowest_pa_empty;
    logic               highest_pa_empty;
    logic               lowest_temp_empty;
    logic [19:0]        next_lowest_press_alt;
    logic [19:0]        next_highest_press_alt;
    logic [11:0]        next_lowest_temp;
    logic               wr_low_pa;
    logic               wr_high_pa;
    logic               wr_low_temp;
    awm_mode_t          mode;

    // =================================================================
    // comparison datapath
    logic signed [23:0] pa_cur;
    logic signed [23:0] pa_goal_x;
    logic signed [23:0] pa_band_x;
    logic signed [23:0] pa_level [3];
    logic signed [13:0] t_cur;
    logic signed [13:0] t_goal_x;
    logic signed [13:0] t_band_x;
    logic signed [13:0] t_level [3];
    logic [2:0]         pa_above;
    logic [2:0]         t_above;
    logic [2:0]         pa_above_q;
    logic [2:0]         t_above_q;
    logic               have_prev;
    logic [2:0]         pa_mask;
    logic [2:0]         t_mask;
    logic               pa_band_nz;
    logic               t_band_nz;
    logic               pa_in_band;
    logic               t_in_band;
    logic               pa_below_min;
    logic               pa_above_max;
    logic               t_below_min;

    assign mode = altimeter_select ? AWM_ALTIMETER : AWM_BAROMETER;

    // align reading, goal and band to the reading's fixed-point grid
    always_comb begin
        if (mode == AWM_ALTIMETER) begin
            pa_cur    = {{4{sample.press[19]}}, sample.press};
            pa_goal_x = {{4{press_alt_goal[15]}}, press_alt_goal,
                         `AWM_LOW_NIBBLE_ZERO};
            pa_band_x = {4'h0, press_alt_band, `AWM_LOW_NIBBLE_ZERO};
        end else begin
            pa_cur    = {4'h0, sample.press};
            pa_goal_x = {5'h00, press_alt_goal, 3'h0};
            pa_band_x = {5'h00, press_alt_band, 3'h0};
        end
    end

    // signed degree goal, band on the sixteenth-degree grid
    always_comb begin
        t_cur    = {{2{sample.temp[11]}}, sample.temp};
        t_goal_x = {{2{temp_goal[7]}}, temp_goal, `AWM_LOW_NIBBLE_ZERO};
        t_band_x = {2'h0, temp_band, `AWM_LOW_NIBBLE_ZERO};
    end

    // three levels of each window
    assign pa_level[`AWM_LEVEL_LOWER]  = pa_goal_x - pa_band_x;
    assign pa_level[`AWM_LEVEL_CENTRE] = pa_goal_x;
    assign pa_level[`AWM_LEVEL_UPPER]  = pa_goal_x + pa_band_x;
    assign t_level[`AWM_LEVEL_LOWER]   = t_goal_x - t_band_x;
    assign t_level[`AWM_LEVEL_CENTRE]  = t_goal_x;
    assign t_level[`AWM_LEVEL_UPPER]   = t_goal_x + t_band_x;

    // side of each level the current reading sits on
    for (genvar i = 0; i < 3; i++) begin : g_level
        assign pa_above[i] = (pa_cur >= pa_level[i]);
        assign t_above[i]  = (t_cur >= t_level[i]);
    end

    assign pa_band_nz = (press_alt_band != 16'h0000);
    assign t_band_nz  = (temp_band != 8'h00);

    // inside goal plus/minus band, both edges included
    assign pa_in_band = pa_band_nz
                      && pa_above[`AWM_LEVEL_LOWER]
                      && (pa_cur <= pa_level[`AWM_LEVEL_UPPER]);
    assign t_in_band  = t_band_nz
                      && t_above[`AWM_LEVEL_LOWER]
                      && (t_cur <= t_level[`AWM_LEVEL_UPPER]);

    // zero band watches the centre level only
    assign pa_mask = pa_band_nz ? `AWM_ALL_LEVELS : `AWM_CENTRE_ONLY;
    assign t_mask  = t_band_nz ? `AWM_ALL_LEVELS : `AWM_CENTRE_ONLY;

    always_comb begin
        if (mode == AWM_ALTIMETER) begin
            pa_below_min = $signed(sample.press) < $signed(lowest_press_alt);
            pa_above_max = $signed(sample.press) > $signed(highest_press_alt);
        end else begin
            pa_below_min = sample.press < lowest_press_alt;
            pa_above_max = sample.press > highest_press_alt;
        end
    end

    assign t_below_min = $signed(sample.temp) < $signed(lowest_temp);

    // =================================================================
    // host writes
    assign wr_low_pa   = reg_req.wr
                       && (reg_req.addr >= `AWM_LOW_PA_HIGH)
                       && (reg_req.addr <= `AWM_LOW_PA_LOW);
    assign wr_high_pa  = reg_req.wr
                       && (reg_req.addr >= `AWM_HIGH_PA_HIGH)
                       && (reg_req.addr <= `AWM_HIGH_PA_LOW);
    assign wr_low_temp = reg_req.wr
                       && ((reg_req.addr == `AWM_LOW_TEMP_HIGH)
                       || (reg_req.addr == `AWM_LOW_TEMP_LOW));

    // byte merge of a write into the held extremes
    always_comb begin
        next_lowest_press_alt  = lowest_press_alt;
        next_highest_press_alt = highest_press_alt;
        next_lowest_temp       = lowest_temp;
        unique case (reg_req.addr)
            `AWM_LOW_PA_HIGH:   next_lowest_press_alt[19:12]  = reg_req.wdata;
            `AWM_LOW_PA_MID:    next_lowest_press_alt[11:4]   = reg_req.wdata;
            `AWM_LOW_PA_LOW:
                next_lowest_press_alt[3:0] = reg_req.wdata[7:4];
            `AWM_HIGH_PA_HIGH:  next_highest_press_alt[19:12] = reg_req.wdata;
            `AWM_HIGH_PA_MID:   next_highest_press_alt[11:4]  = reg_req.wdata;
            `AWM_HIGH_PA_LOW:
                next_highest_press_alt[3:0] = reg_req.wdata[7:4];
            `AWM_LOW_TEMP_HIGH: next_lowest_temp[11:4]        = reg_req.wdata;
            `AWM_LOW_TEMP_LOW:  next_lowest_temp[3:0] = reg_req.wdata[7:4];
            default: begin
            end
        endcase
    end

    // goal and band registers
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            press_alt_goal <= {`AWM_RESET_BYTE, `AWM_RESET_BYTE};
            press_alt_band <= {`AWM_RESET_BYTE, `AWM_RESET_BYTE};
            temp_goal      <= `AWM_RESET_BYTE;
            temp_band      <= `AWM_RESET_BYTE;
        end else if (reg_req.wr) begin
            unique case (reg_req.addr)
                `AWM_PA_GOAL_HIGH: press_alt_goal[15:8] <= reg_req.wdata;
                `AWM_PA_GOAL_LOW:  press_alt_goal[7:0]  <= reg_req.wdata;
                `AWM_TEMP_GOAL:    temp_goal            <= reg_req.wdata;
                `AWM_PA_BAND_HIGH: press_alt_band[15:8] <= reg_req.wdata;
                `AWM_PA_BAND_LOW:  press_alt_band[7:0]  <= reg_req.wdata;
                `AWM_TEMP_BAND:    temp_band            <= reg_req.wdata;
                default: begin
                end
            endcase
        end
    end

    // =================================================================
    // extremes; a capture wins over a host write in the same cycle
    // lowest pressure/altitude
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            lowest_press_alt <= 20'h00000;
            lowest_pa_empty  <= 1'b1;
        end else if (sample_valid && (lowest_pa_empty || pa_below_min)) begin
            lowest_press_alt <= sample.press;
            lowest_pa_empty  <= 1'b0;
        end else if (wr_low_pa) begin
            lowest_press_alt <= next_lowest_press_alt;
            lowest_pa_empty  <= (next_lowest_press_alt == 20'h00000);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            highest_press_alt <= 20'h00000;
            highest_pa_empty  <= 1'b1;
        end else if (sample_valid
                     && (highest_pa_empty || pa_above_max)) begin
            highest_press_alt <= sample.press;
            highest_pa_empty  <= 1'b0;
        end else if (wr_high_pa) begin
            highest_press_alt <= next_highest_press_alt;
            highest_pa_empty  <= (next_highest_press_alt == 20'h00000);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            lowest_temp       <= 12'h000;
            lowest_temp_empty <= 1'b1;
        end else if (sample_valid && (lowest_temp_empty || t_below_min)) begin
            lowest_temp       <= sample.temp;
            lowest_temp_empty <= 1'b0;
        end else if (wr_low_temp) begin
            lowest_temp       <= next_lowest_temp;
            lowest_temp_empty <= (next_lowest_temp == 12'h000);
        end
    end

    // =================================================================
    // alarm flags
    // previous side of each level, for crossing detection
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            pa_above_q <= 3'h0;
            t_above_q  <= 3'h0;
            have_prev  <= 1'b0;
        end else if (sample_valid) begin
            pa_above_q <= pa_above;
            t_above_q  <= t_above;
            have_prev  <= 1'b1;
        end
    end

    // band alerts hold the last reading's verdict
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            press_band_alert_status <= 1'b0;
            temp_band_alert_status  <= 1'b0;
        end else if (sample_valid) begin
            press_band_alert_status <= pa_in_band;
            temp_band_alert_status  <= t_in_band;
        end
    end

    // crossing flags pulse for one cycle per reading
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            press_threshold_cross_status <= 1'b0;
            temp_threshold_cross_status  <= 1'b0;
        end else begin
            press_threshold_cross_status <= sample_valid && have_prev
                && |((pa_above ^ pa_above_q) & pa_mask);
            temp_threshold_cross_status  <= sample_valid && have_prev
                && |((t_above ^ t_above_q) & t_mask);
        end
    end

    // =================================================================
    // read data, one cycle after the read strobe
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            reg_rdata <= `AWM_RESET_BYTE;
        end else if (reg_req.rd) begin
            unique case (reg_req.addr)
                `AWM_PA_GOAL_HIGH:  reg_rdata <= press_alt_goal[15:8];
                `AWM_PA_GOAL_LOW:   reg_rdata <= press_alt_goal[7:0];
                `AWM_TEMP_GOAL:     reg_rdata <= temp_goal;
                `AWM_PA_BAND_HIGH:  reg_rdata <= press_alt_band[15:8];
                `AWM_PA_BAND_LOW:   reg_rdata <= press_alt_band[7:0];
                `AWM_TEMP_BAND:     reg_rdata <= temp_band;
                // same bit layout in pressure mode
                `AWM_LOW_PA_HIGH:   reg_rdata <= lowest_press_alt[19:12];
                `AWM_LOW_PA_MID:    reg_rdata <= lowest_press_alt[11:4];
                `AWM_LOW_PA_LOW:
                    reg_rdata <= {lowest_press_alt[3:0], `AWM_LOW_NIBBLE_ZERO};
                `AWM_LOW_TEMP_HIGH: reg_rdata <= lowest_temp[11:4];
                `AWM_LOW_TEMP_LOW:
                    reg_rdata <= {lowest_temp[3:0], `AWM_LOW_NIBBLE_ZERO};
                `AWM_HIGH_PA_HIGH:  reg_rdata <= highest_press_alt[19:12];
                `AWM_HIGH_PA_MID:   reg_rdata <= highest_press_alt[11:4];
                `AWM_HIGH_PA_LOW:
                    reg_rdata <= {highest_press_alt[3:0], `AWM_LOW_NIBBLE_ZERO};
                default:            reg_rdata <= `AWM_UNMAPPED_READ;
            endcase
        end
    end

endmodule

// file: verif/awm_alarm_capture_props.sv
`timescale 1ns/100ps
`include "awm_defs.svh"
// =====================================================================
// port-level checks of the alarm and capture block
module awm_alarm_capture_props
    import awm_pkg::*;
(
    input wire logic         core_clk,
    input wire logic         reset_n,
    input wire awm_reg_req_t reg_req,
    input wire logic         altimeter_select,
    input wire logic         sample_valid,
    input wire awm_sample_t  sample,
    input wire logic [7:0]   reg_rdata,
    input wire logic         press_band_alert_status,
    input wire logic         press_threshold_cross_status,
    input wire logic         temp_band_alert_status,
    input wire logic         temp_threshold_cross_status
);
    logic [15:0] pa_band;
    logic [7:0]  temp_band;
    logic [7:0]  goal_high;
    logic        seen_sample;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    // shadow of the goal high byte and the band bytes written by the host
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            pa_band   <= 16'h0000;
            temp_band <= 8'h00;
            goal_high <= 8'h00;
        end else if (reg_req.wr) begin
            case (reg_req.addr)
                `AWM_PA_GOAL_HIGH: goal_high     <= reg_req.wdata;
                `AWM_PA_BAND_HIGH: pa_band[15:8] <= reg_req.wdata;
                `AWM_PA_BAND_LOW:  pa_band[7:0]  <= reg_req.wdata;
                `AWM_TEMP_BAND:    temp_band     <= reg_req.wdata;
                default: ;
            endcase
        end
    end

    // history marker: no crossing can be judged without one
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            seen_sample <= 1'b0;
        end else if (sample_valid) begin
            seen_sample <= 1'b1;
        end
    end

    sequence s_first_sample;
        sample_valid && !seen_sample;
    endsequence
    sequence s_goal_read;
        reg_req.rd && reg_req.addr == `AWM_PA_GOAL_HIGH;
    endsequence

    property p_pa_zero_band;
        sample_valid && pa_band == 16'h0000 |=> !press_band_alert_status;
    endproperty
    property p_temp_zero_band;
        sample_valid && temp_band == 8'h00 |=> !temp_band_alert_status;
    endproperty
    property p_pa_cross_cause;
        press_threshold_cross_status |-> $past(sample_valid);
    endproperty
    property p_temp_cross_cause;
        temp_threshold_cross_status |-> $past(sample_valid);
    endproperty
    property p_band_holds;
        !sample_valid |=>
            $stable({press_band_alert_status, temp_band_alert_status});
    endproperty
    property p_first_quiet;
        s_first_sample |=>
            !press_threshold_cross_status && !temp_threshold_cross_status;
    endproperty
    property p_nibble_zero;
        reg_req.rd && (reg_req.addr inside {`AWM_LOW_PA_LOW,
            `AWM_LOW_TEMP_LOW, `AWM_HIGH_PA_LOW})
            |=> reg_rdata[3:0] == `AWM_LOW_NIBBLE_ZERO;
    endproperty
    property p_goal_readback;
        s_goal_read |=> reg_rdata == $past(goal_high);
    endproperty

    a_pa_zero_band: assert property (p_pa_zero_band)
        else $error("pressure band alert with zero band");
    a_temp_zero_band: assert property (p_temp_zero_band)
        else $error("temperature band alert with zero band");
    a_pa_cross_cause: assert property (p_pa_cross_cause)
        else $error("pressure crossing pulse without a sample");
    a_temp_cross_cause: assert property (p_temp_cross_cause)
        else $error("temperature crossing pulse without a sample");
    a_band_holds: assert property (p_band_holds)
        else $error("band status moved without a sample");
    a_first_quiet: assert property (p_first_quiet)
        else $error("crossing flagged on first sample");
    a_nibble_zero: assert property (p_nibble_zero)
        else $error("extreme low nibble not zero");
    a_goal_readback: assert property (p_goal_readback)
        else $error("goal high byte read back wrong");
endmodule

bind awm_alarm_capture awm_alarm_capture_props awm_alarm_capture_props_i (
    .core_clk                     (core_clk),
    .reset_n                      (reset_n),
    .reg_req                      (reg_req),
    .altimeter_select             (altimeter_select),
    .sample_valid                 (sample_valid),
    .sample                       (sample),
    .reg_rdata                    (reg_rdata),
    .press_band_alert_status      (press_band_alert_status),
    .press_threshold_cross_status (press_threshold_cross_status),
    .temp_band_alert_status       (temp_band_alert_status),
    .temp_threshold_cross_status  (temp_threshold_cross_status)
);

// file: verif/awm_host_model.sv
`timescale 1ns/100ps
// =====================================================================
// host side of the register port: one access at a time
module awm_host_model
    import awm_pkg::*;
(
    input  wire logic       core_clk,
    output awm_reg_req_t    reg_req,
    input  wire logic [7:0] reg_rdata
);
    initial reg_req = '0;

    // one write, held up to the edge that takes it
    task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge core_clk);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(posedge core_clk);
        reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
    endtask

    // one read; data is taken once the registered answer has settled
    task automatic rd_reg(input logic [7:0] addr, output logic [7:0] data);
        @(posedge core_clk);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        @(posedge core_clk);
        reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: 8'hFF};
        @(negedge core_clk);
        data = reg_rdata;
    endtask

    task automatic clear_group(input logic [7:0] first, input int count);
        for (int i = 0; i < count; i++) begin
            wr_reg(first + i[7:0], 8'h00);
        end
    endtask
endmodule

// file: verif/test_alarm_window_minmax_capture.sv
`timescale 1ns/100ps
module test_alarm_window_minmax_capture
    import awm_pkg::*;
;
    logic         core_clk;
    logic         reset_n;
    awm_reg_req_t reg_req;
    logic         altimeter_select;
    logic         sample_valid;
    awm_sample_t  sample;
    logic [7:0]   reg_rdata;
    logic         pb;
    logic         pc;
    logic         tb;
    logic         tc;
    int           miscompares;
    int           checked;

    // =================================================================
    // clock, device and host
    initial core_clk = 1'b0;
    always #5 core_clk = ~core_clk;

    awm_alarm_capture awm_alarm_capture_i (
        .core_clk                     (core_clk),
        .reset_n                      (reset_n),
        .reg_req                      (reg_req),
        .altimeter_select             (altimeter_select),
        .sample_valid                 (sample_valid),
        .sample                       (sample),
        .reg_rdata                    (reg_rdata),
        .press_band_alert_status      (pb),
        .press_threshold_cross_status (pc),
        .temp_band_alert_status       (tb),
        .temp_threshold_cross_status  (tc)
    );
    awm_host_model awm_host_model_i (
        .core_clk  (core_clk),
        .reg_req   (reg_req),
        .reg_rdata (reg_rdata)
    );

    // =================================================================
    // shared tasks
    task automatic check_value(input logic [31:0] seen,
                               input logic [31:0] expected);
        checked++;
        if (seen !== expected) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, expected);
        end
    endtask

    task automatic expect_reg(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] data;
        awm_host_model_i.rd_reg(addr, data);
        check_value({24'h000000, data}, {24'h000000, exp});
    endtask

    // one reading; flags {pc, pb, tc, tb} judged the cycle after
    task automatic put_sample(input logic [19:0] press,
                              input logic [11:0] temp,
                              input logic [3:0]  exp);
        @(posedge core_clk);
        sample_valid <= 1'b1;
        sample       <= '{press: press, temp: temp};
        @(posedge core_clk);
        sample_valid <= 1'b0;
        sample       <= '{press: ~press, temp: ~temp};
        #1;
        check_value({28'h0, pc, pb, tc, tb}, {28'h0, exp});
    endtask

    task automatic apply_reset();
        @(posedge core_clk);
        reset_n <= 1'b0;
        repeat (8) @(posedge core_clk);
        reset_n <= 1'b1;
    endtask

    task automatic complete_run();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // =================================================================
    // scenarios
    task automatic check_cleared();
        for (int a = 8'h15; a <= 8'h24; a++) begin
            expect_reg(a[7:0], 8'h00);
        end
    endtask

    task automatic goal_band_readback();
        for (int a = 8'h16; a <= 8'h1B; a++) begin
            awm_host_model_i.wr_reg(a[7:0], 8'hA0 + a[7:0]);
        end
        awm_host_model_i.wr_reg(8'h24, 8'h5A);
        for (int a = 8'h16; a <= 8'h1B; a++) begin
            expect_reg(a[7:0], 8'hA0 + a[7:0]);
        end
        expect_reg(8'h24, 8'h00);
    endtask

    // goal -10 m, band 2 m; temperature goal 25, band zero
    task automatic altitude_alarms();
        @(posedge core_clk);
        altimeter_select <= 1'b1;
        awm_host_model_i.wr_reg(8'h16, 8'hFF);
        awm_host_model_i.wr_reg(8'h17, 8'hF6);
        awm_host_model_i.wr_reg(8'h18, 8'h19);
        awm_host_model_i.wr_reg(8'h19, 8'h00);
        awm_host_model_i.wr_reg(8'h1A, 8'h02);
        awm_host_model_i.wr_reg(8'h1B, 8'h00);
        put_sample(20'hFFEC8, 12'h134, 4'b0000);
        put_sample(20'hFFF50, 12'h140, 4'b1100);
        put_sample(20'hFFF50, 12'h140, 4'b0100);
        put_sample(20'hFFFB0, 12'h1E0, 4'b1010);
        put_sample(20'h00030, 12'h1E0, 4'b0000);
        expect_reg(8'h1C, 8'hFF);
        expect_reg(8'h1D, 8'hEC);
        expect_reg(8'h1E, 8'h80);
        expect_reg(8'h21, 8'h00);
        expect_reg(8'h22, 8'h03);
        expect_reg(8'h23, 8'h00);
        expect_reg(8'h1F, 8'h13);
        expect_reg(8'h20, 8'h40);
    endtask

    // goal 2048 in Pa*4, band 32; temperature band 2
    // the first reading is judged against the sides left by the altitude run
    task automatic pressure_alarms();
        @(posedge core_clk);
        altimeter_select <= 1'b0;
        awm_host_model_i.wr_reg(8'h16, 8'h01);
        awm_host_model_i.wr_reg(8'h17, 8'h00);
        awm_host_model_i.wr_reg(8'h1A, 8'h04);
        awm_host_model_i.wr_reg(8'h1B, 8'h02);
        awm_host_model_i.clear_group(8'h1C, 5);
        awm_host_model_i.clear_group(8'h21, 3);
        expect_reg(8'h1C, 8'h00);
        expect_reg(8'h23, 8'h00);
        put_sample(20'h00705, 12'h1E0, 4'b1000);
        put_sample(20'h007E0, 12'h190, 4'b1111);
        put_sample(20'h007E0, 12'h190, 4'b0101);
        put_sample(20'h00834, 12'h15C, 4'b1010);
        put_sample(20'hF0000, 12'h15C, 4'b0000);
        expect_reg(8'h1C, 8'h00);
        expect_reg(8'h1D, 8'h70);
        expect_reg(8'h1E, 8'h50);
        expect_reg(8'h21, 8'hF0);
        expect_reg(8'h22, 8'h00);
        expect_reg(8'h1F, 8'h15);
        expect_reg(8'h20, 8'hC0);
        // zero band: in-band reading gives no alert, centre crossing only
        awm_host_model_i.wr_reg(8'h1A, 8'h00);
        put_sample(20'h007F0, 12'h15C, 4'b1000);
    endtask

    // =================================================================
    // main sequence and hang guard
    initial begin
        reset_n          = 1'b0;
        altimeter_select = 1'b0;
        sample_valid     = 1'b0;
        sample           = '0;
        miscompares      = 0;
        checked          = 0;
        apply_reset();
        check_cleared();
        goal_band_readback();
        altitude_alarms();
        pressure_alarms();
        apply_reset();
        check_cleared();
        complete_run();
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        complete_run();
    end
endmodule
